// *** core/spc_regs.v ***
/*
  Serial port configuration register bank of a clock generator.
  Holds data pin arrangement, bit order and address direction, the
  self-clearing soft reset and the readback bank select.
  A soft reset write takes none of the other bits of its byte. The clear
  waits for the next serial clock tick, so a stalled serial clock leaves
  the soft reset bit standing. Upper bits stored in spi mode are kept, unless
  a soft reset clears them, but act and read back as zero, while the port is in i2c mode.
  Assumes a serial protocol engine (spi or i2c) decodes frames and presents
  byte-wide register accesses synchronous to i_clk, plus a one-cycle tick
  for each serial clock cycle of the port in use.
*/
`timescale 1ns/1ns
`include "spc_map.vh"

module spc_regs #(
  parameter ADDR_W = `SPC_ADDR_W,
  parameter DATA_W = `SPC_DATA_W
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // port mode
  input wire i_i2c_mode,
  input wire i_sclk_tick,
  // register write
  input wire i_wr_en,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  // register read
  input wire i_rd_en,
  input wire i_own_reg,
  input wire [DATA_W-1:0] i_buf_rdata,
  input wire [DATA_W-1:0] i_act_rdata,
  output reg [DATA_W-1:0] o_rdata,
  output reg o_rvalid,
  // multi-byte address stepping
  output reg [ADDR_W-1:0] o_next_addr,
  // serial write bit capture
  input wire i_rx_bit_valid,
  input wire i_rx_bit,
  output reg [DATA_W-1:0] o_rx_byte,
  // read data serialiser
  input wire i_tx_load,
  input wire [DATA_W-1:0] i_tx_byte,
  input wire i_tx_shift,
  input wire i_read_phase,
  // configuration out
  output reg o_soft_reset,
  output reg o_readback_active,
  output reg o_lsb_first,
  output reg o_separate_output_pin_select,
  // data pins
  output wire o_sdio_o,
  output wire o_sdio_oe,
  output wire o_sdo_o,
  output wire o_sdo_oe
);

  reg sdo_sel_reg;
  reg lsb_first_reg;
  reg soft_rst_reg;
  reg rb_active_reg;
  reg sr_pending_reg;
  reg [DATA_W-1:0] cfg_view;
  reg [DATA_W-1:0] rd_next;
  wire wr_cfg;
  wire wr_rbsel;
  wire soft_wr;
  wire eff_lsb_first;
  wire eff_sdo_sel;

  // decode
  assign wr_cfg = i_wr_en & (i_addr == `SPC_ADDR_CFG);
  assign wr_rbsel = i_wr_en & (i_addr == `SPC_ADDR_RBSEL);
  assign soft_wr = wr_cfg & i_wdata[`SPC_CFG_SOFT_RST];

  // i2c mode disregards the upper two configuration bits
  assign eff_lsb_first = lsb_first_reg & ~i_i2c_mode;
  assign eff_sdo_sel = sdo_sel_reg & ~i_i2c_mode;

  ////////////////////////////////////////////////////////////////////////////
  // data pin select and bit order fields, back to defaults on soft reset
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sdo_sel_reg <= 1'b0;
      lsb_first_reg <= 1'b0;
    end else if (wr_cfg) begin
      if (i_wdata[`SPC_CFG_SOFT_RST]) begin
        // other bits of a soft reset byte are not taken
        sdo_sel_reg <= 1'b0;
        lsb_first_reg <= 1'b0;
      end else if (!i_i2c_mode) begin
        sdo_sel_reg <= i_wdata[`SPC_CFG_SDO_SEL];
        lsb_first_reg <= i_wdata[`SPC_CFG_LSB_FIRST];
      end
    end
  end

  // soft reset bit, self-clearing on the first serial clock tick after it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_rst_reg <= 1'b0;
      sr_pending_reg <= 1'b0;
    end else if (soft_wr) begin
      // a new write wins over a clear arriving in the same cycle
      soft_rst_reg <= 1'b1;
      sr_pending_reg <= 1'b1;
    end else if (sr_pending_reg && i_sclk_tick) begin
      // other register writes never hold the clear back
      soft_rst_reg <= 1'b0;
      sr_pending_reg <= 1'b0;
    end
  end

  // readback bank select, back to the buffer bank on soft reset
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rb_active_reg <= 1'b0;
    end else if (soft_wr) begin
      rb_active_reg <= 1'b0;
    end else if (wr_rbsel) begin
      rb_active_reg <= i_wdata[`SPC_RBSEL_ACTIVE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration readback view, mirrored and with unused bits zero
  always @* begin
    cfg_view = `SPC_ZERO_BYTE;
    cfg_view[`SPC_CFG_SOFT_RST] = soft_rst_reg;
    cfg_view[`SPC_CFG_SOFT_RST_MIR] = soft_rst_reg;
    cfg_view[`SPC_CFG_LSB_FIRST] = eff_lsb_first;
    cfg_view[`SPC_CFG_LSB_FIRST_MIR] = eff_lsb_first;
    cfg_view[`SPC_CFG_SDO_SEL] = eff_sdo_sel;
    cfg_view[`SPC_CFG_SDO_SEL_MIR] = eff_sdo_sel;
  end

  // read source select
  always @* begin
    if (i_own_reg && i_addr == `SPC_ADDR_CFG) begin
      rd_next = cfg_view;
    end else if (i_own_reg && i_addr == `SPC_ADDR_RBSEL) begin
      rd_next = {{(DATA_W-1){1'b0}}, rb_active_reg};
    end else if (rb_active_reg) begin
      rd_next = i_act_rdata;
    end else begin
      rd_next = i_buf_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the request
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `SPC_ZERO_BYTE;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rd_next;
      end
    end
  end

  // address of the next byte in a multi-byte transfer
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_next_addr <= {ADDR_W{1'b0}};
    end else if (eff_lsb_first) begin
      o_next_addr <= i_addr + `SPC_ADDR_ONE;
    end else begin
      o_next_addr <= i_addr - `SPC_ADDR_ONE;
    end
  end

  // write bits gathered into a byte in the selected bit order
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_byte <= `SPC_ZERO_BYTE;
    end else if (i_rx_bit_valid) begin
      if (eff_lsb_first) begin
        o_rx_byte <= {i_rx_bit, o_rx_byte[DATA_W-1:1]};
      end else begin
        o_rx_byte <= {o_rx_byte[DATA_W-2:0], i_rx_bit};
      end
    end
  end

  // effective configuration, registered for the rest of the device
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_soft_reset <= 1'b0;
      o_readback_active <= 1'b0;
      o_lsb_first <= 1'b0;
      o_separate_output_pin_select <= 1'b0;
    end else begin
      o_soft_reset <= soft_rst_reg;
      o_readback_active <= rb_active_reg;
      o_lsb_first <= eff_lsb_first;
      o_separate_output_pin_select <= eff_sdo_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin steering
  spc_pin_steer #(
    .DATA_W(DATA_W)
  ) u_pin_steer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(i_tx_load),
    .i_byte(i_tx_byte),
    .i_shift(i_tx_shift),
    .i_read_phase(i_read_phase),
    .i_lsb_first(eff_lsb_first),
    .i_sdo_sel(eff_sdo_sel),
    .o_sdio_o(o_sdio_o),
    .o_sdio_oe(o_sdio_oe),
    .o_sdo_o(o_sdo_o),
    .o_sdo_oe(o_sdo_oe)
  );

endmodule // spc_regs

// *** core/spc_map.vh ***
/*
  Constants for the serial port configuration register bank:
  register addresses, field positions, reset values and bus widths.
  Assumes it is included by bare name from the design files in core/.
*/
// Overview of operation
// - default: one shared data pin, output pin floats
// - select set: reads drive separate output pin
// - order clear: msb first, address decrements
// - order set: lsb first, address increments
// - i2c mode ignores upper two config bits
// - spi soft reset, clears next serial clock
// - i2c soft reset, clears next scl cycle
// - readback select picks buffer or active bank
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register addresses
`define SPC_ADDR_W 12
`define SPC_ADDR_CFG 12'h000
`define SPC_ADDR_RBSEL 12'h004
`define SPC_ADDR_ONE 12'h001

////////////////////////////////////////////////////////////////////////////////
// serial port configuration fields
`define SPC_CFG_SDO_SEL 7
`define SPC_CFG_LSB_FIRST 6
`define SPC_CFG_SOFT_RST 5
`define SPC_CFG_SOFT_RST_MIR 2
`define SPC_CFG_LSB_FIRST_MIR 1
`define SPC_CFG_SDO_SEL_MIR 0
`define SPC_CFG_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// readback bank select fields
`define SPC_RBSEL_ACTIVE 0
`define SPC_RBSEL_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// data width
`define SPC_DATA_W 8
`define SPC_ZERO_BYTE 8'h00

`endif

// *** core/spc_pin_steer.v ***
/*
  Read data serialiser and data pin steering.
  Assumes the protocol engine loads one read byte, then shifts it one bit per
  serial clock tick while the read phase is flagged.
*/
`timescale 1ns/1ns
`include "spc_map.vh"

module spc_pin_steer #(
  parameter DATA_W = `SPC_DATA_W
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // read byte source
  input wire i_load,
  input wire [DATA_W-1:0] i_byte,
  input wire i_shift,
  input wire i_read_phase,
  // configuration
  input wire i_lsb_first,
  input wire i_sdo_sel,
  // data pins
  output reg o_sdio_o,
  output reg o_sdio_oe,
  output reg o_sdo_o,
  output reg o_sdo_oe
);

  reg [DATA_W-1:0] shift_reg;
  wire cur_bit;

  // outgoing bit taken from the end that matches the bit order
  assign cur_bit = i_lsb_first ? shift_reg[0] : shift_reg[DATA_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // read byte shifter
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= {DATA_W{1'b0}};
    end else if (i_load) begin
      shift_reg <= i_byte;
    end else if (i_shift) begin
      if (i_lsb_first) begin
        shift_reg <= {1'b0, shift_reg[DATA_W-1:1]};
      end else begin
        shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, one cycle behind the shifter
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdio_o <= 1'b0;
      o_sdio_oe <= 1'b0;
      o_sdo_o <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdio_o <= cur_bit;
      o_sdo_o <= cur_bit;
      o_sdio_oe <= i_read_phase & ~i_sdo_sel;
      o_sdo_oe <= i_read_phase & i_sdo_sel;
    end
  end

endmodule // spc_pin_steer

// *** tb/spc_host_model.sv ***
/* host side model: serial clock ticks and mirrored config bytes.
   assumes the bench clock and a run flag framing each transfer */
`timescale 1ns/1ns
module spc_host_model (
  input wire i_clk,
  input wire i_run,
  input wire [2:0] i_hi,
  output reg o_tick = 1'b0,
  output wire [7:0] o_cfg_byte
);
  reg [1:0] div_reg = 2'h0;
  // one serial clock tick every four clocks, none outside frames
  always @(posedge i_clk) begin
    div_reg <= i_run ? div_reg + 2'h1 : 2'h0;
    o_tick <= i_run && (div_reg == 2'h3);
  end
  // low three bits mirror the high three bits in reverse order, bits 4 and 3 zero
  assign o_cfg_byte = {i_hi, 2'h0, i_hi[0], i_hi[1], i_hi[2]};
endmodule // spc_host_model

// *** tb/spc_regs_props.sv ***
/* assertions on the config bank ports.
   assumes bind onto spc_regs, one clock domain */
`timescale 1ns/1ns
module spc_regs_props #(parameter ADDR_W = 12, parameter DATA_W = 8) (
  // clock, reset and requests
  input wire i_clk, i_rst, i_i2c_mode, i_wr_en, i_rd_en, i_own_reg, i_sclk_tick,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata, i_buf_rdata, i_act_rdata, o_rdata,
  // observed outputs
  input wire [ADDR_W-1:0] o_next_addr,
  input wire o_rvalid, o_soft_reset, o_readback_active, o_lsb_first,
  input wire o_separate_output_pin_select, o_sdo_oe, o_sdio_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire soft_wr = i_wr_en && i_addr == 0 && i_wdata[5];
  a_read_answer: assert property (i_rd_en |=> o_rvalid) else $error("no read answer");
  a_read_active: assert property (i_rd_en && !i_own_reg ##1 o_readback_active
    |-> o_rdata == $past(i_act_rdata)) else $error("wrong active data");
  a_read_buffer: assert property (i_rd_en && !i_own_reg ##1 !o_readback_active
    |-> o_rdata == $past(i_buf_rdata)) else $error("wrong buffer data");
  a_out_pin_float: assert property (o_sdo_oe |-> o_separate_output_pin_select)
    else $error("output pin driven");
  a_sdio_quiet: assert property (o_sdio_oe |-> !o_separate_output_pin_select)
    else $error("shared pin driven for read");
  a_soft_clear: assert property (o_soft_reset && i_sclk_tick && !i_wr_en
    |=> ##1 !o_soft_reset) else $error("soft reset not cleared");
  a_i2c_ignore: assert property ($past(i_i2c_mode) && i_i2c_mode
    |-> !o_lsb_first && !o_separate_output_pin_select) else $error("upper bits kept");
  a_soft_set: assert property (soft_wr |=> ##1 o_soft_reset)
    else $error("soft reset lost");
  a_soft_defaults: assert property (soft_wr |=> ##1 !o_lsb_first && !o_readback_active
    && !o_separate_output_pin_select) else $error("defaults not restored");
  a_addr_step: assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_wr_en)
    && !$past(i_wr_en, 2) |-> o_next_addr == (o_lsb_first ? $past(i_addr) + 1'b1
    : $past(i_addr) - 1'b1)) else $error("address step wrong");
endmodule // spc_regs_props
bind spc_regs spc_regs_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (.*);

// *** tb/tb_top.sv ***
/* self-checking bench for spc_regs.
   assumes spc_host_model and the bound checker */
`timescale 1ns/1ns
module tb_top;
  reg i_clk = 1'b0, i_rst = 1'b1, i2c = 1'b0, wr = 1'b0, rd = 1'b0, own = 1'b0;
  reg rxv = 1'b0, rxb = 1'b0, txl = 1'b0, txs = 1'b0, rph = 1'b0, run = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [7:0] wd = 8'h00, bufd = 8'h00, actd = 8'h00, txd = 8'h00;
  reg [2:0] hi = 3'h0;
  wire tick, rv, sr, ra, lsb, sel, sdio, sdio_oe, sdo, sdo_oe;
  wire [7:0] rdat, rx, cfg;
  wire [11:0] nxt;
  integer error_cnt = 0, cmp_count = 0, seed = 6, k, m;
  always #10 i_clk = ~i_clk;
  spc_host_model host (.i_clk(i_clk), .i_run(run), .i_hi(hi), .o_tick(tick), .o_cfg_byte(cfg));
  spc_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_i2c_mode(i2c), .i_sclk_tick(tick), .i_wr_en(wr),
    .i_addr(addr), .i_wdata(wd), .i_rd_en(rd), .i_own_reg(own), .i_buf_rdata(bufd),
    .i_act_rdata(actd), .o_rdata(rdat), .o_rvalid(rv), .o_next_addr(nxt), .i_rx_bit_valid(rxv),
    .i_rx_bit(rxb), .o_rx_byte(rx), .i_tx_load(txl), .i_tx_byte(txd), .i_tx_shift(txs),
    .i_read_phase(rph), .o_soft_reset(sr), .o_readback_active(ra), .o_lsb_first(lsb),
    .o_separate_output_pin_select(sel), .o_sdio_o(sdio), .o_sdio_oe(sdio_oe), .o_sdo_o(sdo),
    .o_sdo_oe(sdo_oe));
  task cyc; begin @(posedge i_clk); #2; end endtask
  task chk(input [63:0] nm, input [11:0] e, input [11:0] g); begin
    cmp_count = cmp_count + 1;
    if (g !== e) begin error_cnt = error_cnt + 1; $display("BAD %0s exp %h got %h", nm, e, g); end
  end endtask
  task wr_reg(input [11:0] a, input [7:0] d); begin
    addr = a; wd = d; wr = 1'b1; cyc; wr = 1'b0; cyc; cyc;
  end endtask
  task rd_reg(input [11:0] a, input o, input [7:0] e); begin
    addr = a; own = o; rd = 1'b1; cyc; rd = 1'b0;
    chk("rvalid", 12'h1, rv); chk("rdata", e, rdat); cyc;
  end endtask
  task finish_test; begin
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  // watchdog
  initial begin #200000; error_cnt = error_cnt + 1; finish_test; end
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    #2 i_rst = 1'b0;
    rd_reg(12'h000, 1'b1, 8'h00);
    for (m = 0; m < 4; m = m + 1) begin
      hi = {m[1], m[0], 1'b0}; cyc;
      wr_reg(12'h000, cfg);
      chk("lsb", m[0], lsb);
      chk("sel", m[1], sel);
      rd_reg(12'h000, 1'b1, {m[1], m[0], 4'h0, m[0], m[1]});
      addr = $random(seed); cyc;
      chk("next", m[0] ? addr + 12'h1 : addr - 12'h1, nxt);
      txd = $random(seed); txl = 1'b1; rph = 1'b1; cyc; txl = 1'b0; txs = 1'b1;
      chk("sdo_oe", m[1], sdo_oe); chk("sdio_oe", !m[1], sdio_oe);
      for (k = 0; k < 8; k = k + 1) begin
        cyc; chk("bit", m[0] ? txd[k] : txd[7-k], m[1] ? sdo : sdio);
      end
      txs = 1'b0; rph = 1'b0; wd = $random(seed);
      for (k = 0; k < 8; k = k + 1) begin rxv = 1'b1; rxb = m[0] ? wd[k] : wd[7-k]; cyc; end
      rxv = 1'b0; cyc;
      chk("rx", wd, rx);
    end
    wr_reg(12'h004, 8'h01);
    rd_reg(12'h004, 1'b1, 8'h01);
    for (m = 0; m < 6; m = m + 1) begin
      if (m == 3) wr_reg(12'h004, 8'hfe);
      bufd = $random(seed); actd = $random(seed);
      rd_reg(12'h123, 1'b0, m < 3 ? actd : bufd);
    end
    rd_reg(12'h004, 1'b1, 8'h00);
    for (m = 0; m < 2; m = m + 1) begin
      i2c = m[0]; wr_reg(12'h004, 8'h01);
      hi = 3'h7; cyc; wr_reg(12'h000, cfg);
      chk("soft", 12'h1, sr); chk("rbact", 12'h0, ra);
      chk("lsb", 12'h0, lsb); chk("sel", 12'h0, sel);
      run = 1'b1; k = 0;
      while (sr !== 1'b0 && k < 20) begin cyc; k = k + 1; end
      chk("clear", 12'h0, sr); run = 1'b0;
    end
    hi = 3'h6; cyc; wr_reg(12'h000, cfg);
    rd_reg(12'h000, 1'b1, 8'h00);
    i2c = 1'b0; wr_reg(12'h000, cfg); chk("lsb", 12'h1, lsb);
    i2c = 1'b1; cyc; chk("lsb", 12'h0, lsb);
    rd_reg(12'h000, 1'b1, 8'h00);
    finish_test;
  end
endmodule // tb_top
